//--- aif_defines.svh
// constants for the analogue input supervision block
`ifndef AIF_DEFINES_SVH
`define AIF_DEFINES_SVH
`define AIF_SIG_W 16
`define AIF_MV_PER_V 16'h03E8
`define AIF_UA_PER_MA 16'h03E8
`define AIF_V_LOW_RST 16'h0000
`define AIF_V_HIGH_RST 16'h2710
`define AIF_V_MAX 16'h2710
`define AIF_I_LOW_RST 16'h0FA0
`define AIF_I_HIGH_RST 16'h4E20
`define AIF_I_MAX 16'h4E20
`define AIF_V_LZ_MIN 16'h03E8
`define AIF_I_LZ_MIN 16'h07D0
`define AIF_THERM_OHM 16'h0BB8
`define AIF_TMO_RST 7'h0A
`define AIF_TMO_MIN 7'h01
`define AIF_TMO_MAX 7'h63
`define AIF_CLK_HZ 40000000
`define AIF_FN_NONE 2'h0
`define AIF_FN_REF 2'h1
`define AIF_FN_FB 2'h2
`define AIF_FN_THERM 2'h3
`define AIF_ACT_RST 3'h0
`endif

//--- aif_pkg.sv
// types for the analogue input supervision block
package aif_pkg;
  typedef enum logic [1:0] {
    AIF_NONE  = 2'h0,
    AIF_REF   = 2'h1,
    AIF_FB    = 2'h2,
    AIF_THERM = 2'h3
  } aif_func_t;
  typedef enum logic [2:0] {
    AIF_ACT_OFF    = 3'h0,
    AIF_ACT_FREEZE = 3'h1,
    AIF_ACT_STOP   = 3'h2,
    AIF_ACT_JOG    = 3'h3,
    AIF_ACT_FMAX   = 3'h4,
    AIF_ACT_TRIP   = 3'h5
  } aif_action_t;
  typedef enum logic [2:0] {
    AIF_S_IDLE  = 3'b001,
    AIF_S_COUNT = 3'b010,
    AIF_S_LOST  = 3'b100
  } aif_state_t;
endpackage : aif_pkg

//--- aif_scale_if.sv
// scaling request and result between top and scaler
`timescale 1ns/1ps
interface aif_scale_if;
  logic [15:0] sig;
  logic [15:0] low;
  logic [15:0] high;
  logic [15:0] out_min;
  logic [15:0] out_max;
  logic [15:0] result;
  modport top    (output sig, low, high, out_min, out_max, input result);
  modport scaler (input sig, low, high, out_min, out_max, output result);
endinterface : aif_scale_if

//--- aif_scaler.sv
// linear clamped mapping of one input onto an output range
`timescale 1ns/1ps
`include "aif_defines.svh"
module aif_scaler (
  aif_scale_if.scaler s
);
  logic [15:0] span_in;
  logic [15:0] span_out;
  logic [15:0] offs;
  logic [31:0] prod;
  logic [31:0] quot;
  always_comb begin
    span_in  = s.high - s.low;
    span_out = s.out_max - s.out_min;
    offs     = s.sig - s.low;
    prod     = {16'h0000, offs} * {16'h0000, span_out};
    quot     = (span_in == 16'h0000) ? 32'h00000000 : prod / {16'h0000, span_in};
    if (s.high <= s.low || s.sig <= s.low) begin
      s.result = s.out_min;
    end else if (s.sig >= s.high) begin
      s.result = s.out_max;
    end else begin
      s.result = s.out_min + quot[15:0];
    end
  end
endmodule : aif_scaler

//--- aif_supervisor.sv
// analogue input function, scaling and signal loss supervision
`timescale 1ns/1ps
`include "aif_defines.svh"
module aif_supervisor #(
  parameter int unsigned TICKS_PER_S = `AIF_CLK_HZ
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // samples: volts in mV, current in uA, thermistor in ohm
  input  wire logic [15:0] voltage_input_a,
  input  wire logic [15:0] voltage_input_b,
  input  wire logic [15:0] current_input,
  input  wire logic [15:0] thermistor_a_ohm,
  input  wire logic [15:0] thermistor_b_ohm,
  // parameter write port
  input  wire logic        cfg_write,
  input  wire logic [1:0]  voltage_input_a_function,
  input  wire logic [15:0] voltage_input_a_low_point,
  input  wire logic [15:0] voltage_input_a_high_point,
  input  wire logic [1:0]  voltage_input_b_function,
  input  wire logic [15:0] voltage_input_b_low_point,
  input  wire logic [15:0] voltage_input_b_high_point,
  input  wire logic [1:0]  current_input_function,
  input  wire logic [15:0] current_input_low_point,
  input  wire logic [15:0] current_input_high_point,
  input  wire logic [6:0]  signal_loss_timeout,
  input  wire logic [2:0]  signal_loss_action,
  // ranges and drive context
  input  wire logic [15:0] reference_minimum,
  input  wire logic [15:0] reference_maximum,
  input  wire logic [15:0] feedback_minimum,
  input  wire logic [15:0] feedback_maximum,
  input  wire logic        zone_regulation,
  input  wire logic        bus_timeout,
  input  wire logic [2:0]  bus_timeout_action,
  // results
  output logic [17:0]      reference_sum,
  output logic [15:0]      feedback_a,
  output logic [15:0]      feedback_b,
  output logic             thermal_stop,
  output logic             signal_lost,
  output logic [2:0]       fallback_action
);
  localparam int unsigned N = 3;
  localparam logic [31:0] TICKS = 32'(TICKS_PER_S);

  logic [1:0]  func [N];
  logic [15:0] low  [N];
  logic [15:0] high [N];
  logic [6:0]  tmo;
  logic [2:0]  act;
  logic [1:0]  next_func [N];
  logic [15:0] next_low  [N];
  logic [15:0] next_high [N];
  logic [6:0]  next_tmo;
  logic [2:0]  next_act;

  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
    clip = (v > mx) ? mx : v;
  endfunction : clip

  function automatic logic is_used(input logic [1:0] f);
    is_used = (f == `AIF_FN_REF) || (f == `AIF_FN_FB);
  endfunction : is_used

  // parameter store
  always_comb begin
    next_func = func;
    next_low  = low;
    next_high = high;
    next_tmo  = tmo;
    next_act  = act;
    if (cfg_write) begin
      next_func[0] = voltage_input_a_function;
      next_func[1] = voltage_input_b_function;
      next_func[2] = (current_input_function == `AIF_FN_THERM) ? `AIF_FN_NONE : current_input_function;
      next_low[0]  = clip(voltage_input_a_low_point, `AIF_V_MAX);
      next_high[0] = clip(voltage_input_a_high_point, `AIF_V_MAX);
      next_low[1]  = clip(voltage_input_b_low_point, `AIF_V_MAX);
      next_high[1] = clip(voltage_input_b_high_point, `AIF_V_MAX);
      next_low[2]  = clip(current_input_low_point, `AIF_I_MAX);
      next_high[2] = clip(current_input_high_point, `AIF_I_MAX);
      if (signal_loss_timeout < `AIF_TMO_MIN) begin
        next_tmo = `AIF_TMO_MIN;
      end else if (signal_loss_timeout > `AIF_TMO_MAX) begin
        next_tmo = `AIF_TMO_MAX;
      end else begin
        next_tmo = signal_loss_timeout;
      end
      next_act = (signal_loss_action > 3'h5) ? `AIF_ACT_RST : signal_loss_action;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      func[0] <= `AIF_FN_REF;
      func[1] <= `AIF_FN_NONE;
      func[2] <= `AIF_FN_REF;
      low[0]  <= `AIF_V_LOW_RST;
      low[1]  <= `AIF_V_LOW_RST;
      low[2]  <= `AIF_I_LOW_RST;
      high[0] <= `AIF_V_HIGH_RST;
      high[1] <= `AIF_V_HIGH_RST;
      high[2] <= `AIF_I_HIGH_RST;
      tmo     <= `AIF_TMO_RST;
      act     <= `AIF_ACT_RST;
    end else begin
      func <= next_func;
      low  <= next_low;
      high <= next_high;
      tmo  <= next_tmo;
      act  <= next_act;
    end
  end

  // scaling per input
  logic [15:0] sig [N];
  logic [15:0] scaled [N];
  assign sig[0] = voltage_input_a;
  assign sig[1] = voltage_input_b;
  assign sig[2] = current_input;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_scale
      aif_scale_if sif ();
      assign sif.sig     = sig[gi];
      assign sif.low     = low[gi];
      assign sif.high    = high[gi];
      assign sif.out_min = (func[gi] == `AIF_FN_FB) ? feedback_minimum : reference_minimum;
      assign sif.out_max = (func[gi] == `AIF_FN_FB) ? feedback_maximum : reference_maximum;
      assign scaled[gi]  = sif.result;
      aif_scaler u_scaler (.s(sif));
    end
  endgenerate

  // combination of scaled inputs
  logic [17:0] next_ref;
  logic [15:0] next_fb_a;
  logic [15:0] next_fb_b;
  logic        next_therm;
  always_comb begin
    next_ref = 18'h00000;
    for (int i = 0; i < N; i++) begin
      if (func[i] == `AIF_FN_REF) begin
        next_ref = next_ref + {2'h0, scaled[i]};
      end
    end
    next_fb_a = 16'h0000;
    next_fb_b = 16'h0000;
    if (func[0] == `AIF_FN_FB) begin
      next_fb_a = scaled[0];
    end else if (func[2] == `AIF_FN_FB && !zone_regulation) begin
      next_fb_a = scaled[2];
    end
    if (func[1] == `AIF_FN_FB) begin
      next_fb_b = scaled[1];
    end
    next_therm = (func[0] == `AIF_FN_THERM && thermistor_a_ohm > `AIF_THERM_OHM)
              || (func[1] == `AIF_FN_THERM && thermistor_b_ohm > `AIF_THERM_OHM);
  end

  // signal loss watchdog
  logic [N-1:0] below;
  logic [N-1:0] armed;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      below[i] = sig[i] < {1'b0, low[i][15:1]};
      armed[i] = is_used(func[i])
              && (low[i] > ((i == 2) ? `AIF_I_LZ_MIN : `AIF_V_LZ_MIN));
    end
  end

  aif_pkg::aif_state_t st;
  aif_pkg::aif_state_t next_st;
  logic [31:0] tick;
  logic [6:0]  secs;
  logic [31:0] next_tick;
  logic [6:0]  next_secs;
  logic        loss;
  assign loss = |(below & armed);

  always_comb begin
    next_st   = st;
    next_tick = tick;
    next_secs = secs;
    case (st)
      aif_pkg::AIF_S_IDLE: begin
        next_tick = 32'h00000000;
        next_secs = 7'h00;
        if (loss) begin
          next_st = aif_pkg::AIF_S_COUNT;
        end
      end
      aif_pkg::AIF_S_COUNT: begin
        if (!loss) begin
          next_st = aif_pkg::AIF_S_IDLE;
        end else if (tick == TICKS - 32'h1) begin
          next_tick = 32'h00000000;
          next_secs = secs + 7'h01;
          if (secs + 7'h01 >= tmo) begin
            next_st = aif_pkg::AIF_S_LOST;
          end
        end else begin
          next_tick = tick + 32'h1;
        end
      end
      aif_pkg::AIF_S_LOST: begin
        if (!loss) begin
          next_st = aif_pkg::AIF_S_IDLE;
        end
      end
      default: begin
        next_st = aif_pkg::AIF_S_IDLE;
      end
    endcase
  end

  logic [2:0] next_fallback;
  always_comb begin
    if (next_st == aif_pkg::AIF_S_LOST && act != `AIF_ACT_RST) begin
      next_fallback = act;
    end else if (bus_timeout) begin
      next_fallback = bus_timeout_action;
    end else begin
      next_fallback = `AIF_ACT_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st              <= aif_pkg::AIF_S_IDLE;
      tick            <= 32'h00000000;
      secs            <= 7'h00;
      reference_sum   <= 18'h00000;
      feedback_a      <= 16'h0000;
      feedback_b      <= 16'h0000;
      thermal_stop    <= 1'b0;
      signal_lost     <= 1'b0;
      fallback_action <= `AIF_ACT_RST;
    end else begin
      st              <= next_st;
      tick            <= next_tick;
      secs            <= next_secs;
      reference_sum   <= next_ref;
      feedback_a      <= next_fb_a;
      feedback_b      <= next_fb_b;
      thermal_stop    <= next_therm;
      signal_lost     <= (next_st == aif_pkg::AIF_S_LOST);
      fallback_action <= next_fallback;
    end
  end

  // checks
  a_lost_needs_loss: assert property (@(posedge sys_clk) disable iff (!rst_n)
    signal_lost |-> $past(loss)) else $error("signal lost without live zero loss");
  a_thermal_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (func[0] == `AIF_FN_THERM && thermistor_a_ohm > `AIF_THERM_OHM) |=> thermal_stop)
    else $error("thermistor cut-out missed");
  a_analog_wins_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (next_st == aif_pkg::AIF_S_LOST && act != `AIF_ACT_RST && bus_timeout) |=> fallback_action == $past(act))
    else $error("bus action overrode analogue fallback");
  a_no_early_lost: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st == aif_pkg::AIF_S_COUNT) |=> !signal_lost) else $error("lost flagged before timeout");
  a_unarmed_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (armed == 3'b000) |=> st == aif_pkg::AIF_S_IDLE) else $error("watchdog ran while unarmed");
  a_current_no_therm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    func[2] != `AIF_FN_THERM) else $error("thermistor on current input");
  a_action_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act <= 3'h5) else $error("fallback code out of range");
  a_ref_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (func[0] != `AIF_FN_REF && func[1] != `AIF_FN_REF && func[2] != `AIF_FN_REF) |=> reference_sum == 18'h00000)
    else $error("reference from unused input");
endmodule : aif_supervisor

//--- aif_sensor_model.sv
// behavioural sensors and reference sources on the analogue inputs
`timescale 1ns/1ps
module aif_sensor_model (
  // commanded levels
  input  wire logic [15:0] lv_a,
  input  wire logic [15:0] lv_b,
  input  wire logic [15:0] lv_i,
  input  wire logic [15:0] om_a,
  input  wire logic [15:0] om_b,
  // sampled signals
  output logic      [15:0] va,
  output logic      [15:0] vb,
  output logic      [15:0] ci,
  output logic      [15:0] tha,
  output logic      [15:0] thb
);
  assign va  = lv_a;
  assign vb  = lv_b;
  assign ci  = lv_i;
  assign tha = om_a;
  assign thb = om_b;
endmodule : aif_sensor_model

//--- tb_analog_input_function_timeout.sv
// self-checking bench for the analogue input supervisor
`timescale 1ns/1ps
module tb_analog_input_function_timeout;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [15:0] lv_a = 16'h0BB8, lv_b = 16'h1B58, lv_i = 16'h2EE0, om_a = 16'h0, om_b = 16'h0;
  logic [15:0] va, vb, ci, tha, thb;
  logic        cfg = 1'b0, zone = 1'b0, bus = 1'b0;
  logic [1:0]  fa = 2'h1, fb = 2'h0, fi = 2'h1;
  logic [15:0] la = 16'h0, ha = 16'h2710, li = 16'h0, hi = 16'h2710;
  logic [15:0] lb = 16'h0, hb = 16'h2710;
  logic [6:0]  tmo = 7'h02;
  logic [2:0]  act = 3'h0, bact = 3'h2;
  logic [17:0] ref_sum;
  logic [15:0] fb_a, fb_b;
  logic        therm, lost;
  logic [2:0]  fall;
  logic [31:0] lfsr = 32'h18CCF8DE;
  logic [6:0]  cfgs [6] = '{7'b01_00_01_0, 7'b01_01_01_0, 7'b10_10_00_1, 7'b00_11_10_0, 7'b11_00_11_0,
                            7'b00_10_10_1};
  int          n_errors = 0, num_checks = 0, cyc = 0;

  aif_sensor_model snd_u (.lv_a(lv_a), .lv_b(lv_b), .lv_i(lv_i), .om_a(om_a), .om_b(om_b),
    .va(va), .vb(vb), .ci(ci), .tha(tha), .thb(thb));

  aif_supervisor #(.TICKS_PER_S(10)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .voltage_input_a(va), .voltage_input_b(vb), .current_input(ci),
    .thermistor_a_ohm(tha), .thermistor_b_ohm(thb), .cfg_write(cfg),
    .voltage_input_a_function(fa), .voltage_input_a_low_point(la), .voltage_input_a_high_point(ha),
    .voltage_input_b_function(fb), .voltage_input_b_low_point(lb), .voltage_input_b_high_point(hb),
    .current_input_function(fi), .current_input_low_point(li), .current_input_high_point(hi),
    .signal_loss_timeout(tmo), .signal_loss_action(act),
    .reference_minimum(16'h0), .reference_maximum(16'h2710),
    .feedback_minimum(16'h0), .feedback_maximum(16'h2710),
    .zone_regulation(zone), .bus_timeout(bus), .bus_timeout_action(bact),
    .reference_sum(ref_sum), .feedback_a(fb_a), .feedback_b(fb_b),
    .thermal_stop(therm), .signal_lost(lost), .fallback_action(fall));

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  // clamped linear map onto 0..10000
  function automatic logic [15:0] scl(input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hh);
    if (s <= lo) return 16'h0;
    if (s >= hh) return 16'h2710;
    return 16'((32'(s) - 32'(lo)) * 32'h2710 / (32'(hh) - 32'(lo)));
  endfunction : scl

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt

  task automatic load;
    cfg = 1'b1;
    wt(1);
    cfg = 1'b0;
    wt(3);
  endtask : load

  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    logic [1:0] ef;
    wt(2);
    rst_n = 1'b1;
    wt(3);
    chk(ref_sum, 18'h1F40);
    chk(lost, 1'b0);
    chk(fall, 3'h0);
    // function table with random samples
    for (int k = 0; k < 6; k++) begin
      {fa, fb, fi, zone} = cfgs[k];
      lb = 16'(k) * 16'h00C8;
      hb = 16'h2710 - 16'(k) * 16'h0190;
      load();
      ef = (fi == 2'h3) ? 2'h0 : fi;
      for (int j = 0; j < 8; j++) begin
        lfsr = rnd(lfsr);
        lv_a = {2'h0, lfsr[13:0]};
        lv_i = {2'h0, lfsr[27:14]};
        lv_b = lfsr[31:16];
        om_a = 16'h0B54 + 16'(lfsr[7:0]);
        om_b = 16'h0B54 + 16'(lfsr[15:8]);
        wt(3);
        chk(ref_sum, 18'(fa == 2'h1 ? scl(lv_a, la, ha) : 16'h0) + 18'(fb == 2'h1 ? scl(lv_b, lb, hb) : 16'h0)
          + 18'(ef == 2'h1 ? scl(lv_i, li, hi) : 16'h0));
        chk(fb_a, fa == 2'h2 ? scl(lv_a, la, ha) : (ef == 2'h2 && !zone) ? scl(lv_i, li, hi) : 16'h0);
        chk(fb_b, fb == 2'h2 ? scl(lv_b, lb, hb) : 16'h0);
        chk(therm, (fa == 2'h3 && lv_a >= 0 && om_a > 16'h0BB8) || (fb == 2'h3 && om_b > 16'h0BB8));
      end
    end
    // signal loss with every fallback code, bus watchdog active
    {fa, fb, fi, zone} = 7'b01_00_00_0;
    bus = 1'b1;
    lv_a = 16'h1388;
    for (int k = 0; k < 7; k++) begin
      la = (k == 6) ? 16'h03E8 : 16'h07D0;
      act = 3'(k % 6);
      bact = 3'(5 - k % 6);
      load();
      lv_a = 16'h0384;
      wt(15);
      chk(fall, bact);
      wt(11);
      chk(lost, k != 6);
      chk(fall, (k != 0 && k != 6) ? act : bact);
      lv_a = 16'h1388;
      wt(3);
      chk(lost, 1'b0);
      chk(fall, bact);
    end
    stop_test();
  end
endmodule : tb_analog_input_function_timeout
